// ==== hdl/implied_seq_regs.svh ====
// Constants for the implied-mode bus cycle sequencer.
// Assumes inclusion by the sequencer and the bench only.
`ifndef IMPLIED_SEQ_REGS_SVH
`define IMPLIED_SEQ_REGS_SVH

// ----------------------------------------------------------------------------
// Fixed bus address and wait-frame stack offset
// ----------------------------------------------------------------------------
`define DUMMY_ADDR        16'hFFFF
`define WAIT_SP_OFFSET    16'h0007

// ----------------------------------------------------------------------------
// Reset values of the programmer registers
// ----------------------------------------------------------------------------
`define RST_PC            16'h0000
`define RST_SP            16'h00FF
`define RST_X             16'h0000
`define RST_ACC           8'h00
`define RST_CCR           8'h00

// ----------------------------------------------------------------------------
// Cycle counts per opcode class
// ----------------------------------------------------------------------------
`define CYC_INH           4'h2
`define CYC_SHORT         4'h3
`define CYC_PULL_ACC      4'h4
`define CYC_PUSH_X        4'h4
`define CYC_PULL_X        4'h5
`define CYC_RETURN        4'h5
`define CYC_WAIT          4'h9

`endif

// ==== hdl/implied_seq_pkg.sv ====
// Types shared by the implied-mode bus cycle sequencer and its bench.
// Assumes the constant header sits beside this file.
package implied_seq_pkg;

  typedef enum logic [3:0] {
    CL_INHERENT  = 4'h0,  // two-cycle register-only ops
    CL_IRR_FFFF  = 4'h1,  // add_b_to_index_op, double_acc_shift_left/right_op
    CL_SP_INC    = 4'h2,  // stack_ptr_increment_op
    CL_SP_DEC    = 4'h3,
    CL_X_INC     = 4'h4,  // index_increment_op
    CL_X_DEC     = 4'h5,  // index_decrement_op
    CL_X_TO_SP   = 4'h6,  // index_to_stack_ptr_op
    CL_SP_TO_X   = 4'h7,  // stack_ptr_to_index_op
    CL_PUSH_A    = 4'h8,  // push_acc_a_op
    CL_PUSH_B    = 4'h9,  // push_acc_b_op
    CL_PULL_A    = 4'hA,  // pull_acc_a_op
    CL_PULL_B    = 4'hB,  // pull_acc_b_op
    CL_PUSH_X    = 4'hC,  // push_index_op
    CL_PULL_X    = 4'hD,  // pull_index_op
    CL_RETURN    = 4'hE,  // subroutine return
    CL_WAIT      = 4'hF   // wait_for_interrupt_op
  } op_class_e;

  typedef enum logic [1:0] {
    PH_RUN  = 2'b00,
    PH_WAIT = 2'b01
  } phase_e;

  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  dout;
    logic        dout_oe_n;
    logic        fetch;
  } bus_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] x;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  ccr;
  } cpu_regs_s;

  typedef struct packed {
    phase_e      phase;
    op_class_e   cls;
    logic [3:0]  cyc;
    logic [7:0]  hold;
    cpu_regs_s   r;
    bus_s        bus;
  } seq_state_s;

endpackage : implied_seq_pkg

// ==== hdl/implied_mode_bus_cycle_sequencer.sv ====
// Bus cycle sequencer for implied-mode opcodes of an 8-bit core.
// Assumes an outside decoder maps the byte on data_in to op_class
// combinationally during every opcode fetch cycle, and a bus whose
// reads have no side effects.
`timescale 1ns/1ps
`default_nettype none
`include "implied_seq_regs.svh"

module implied_mode_bus_cycle_sequencer
  import implied_seq_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      arst_n,
  input  wire logic [7:0] data_in,
  input  var  op_class_e op_class,
  input  wire logic      wake,
  output logic [15:0]    addr,
  output logic           rw,
  output logic [7:0]     data_out,
  output logic           data_oe_n,
  output logic           opcode_fetch,
  output logic           wait_halt,
  output cpu_regs_s      cpu_regs
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [3:0] cycles_of(input op_class_e c);
    unique case (c)
      CL_INHERENT:            cycles_of = `CYC_INH;
      CL_PULL_A, CL_PULL_B:   cycles_of = `CYC_PULL_ACC;
      CL_PUSH_X:              cycles_of = `CYC_PUSH_X;
      CL_PULL_X:              cycles_of = `CYC_PULL_X;
      CL_RETURN:              cycles_of = `CYC_RETURN;
      CL_WAIT:                cycles_of = `CYC_WAIT;
      default:                cycles_of = `CYC_SHORT;
    endcase
  endfunction : cycles_of

  function automatic bus_s rd(input logic [15:0] a, input logic f);
    rd.addr      = a;
    rd.rw        = 1'b1;
    rd.dout      = 8'h00;
    rd.dout_oe_n = 1'b1;
    rd.fetch     = f;
  endfunction : rd

  function automatic bus_s wr(input logic [15:0] a, input logic [7:0] d);
    wr.addr      = a;
    wr.rw        = 1'b0;
    wr.dout      = d;
    wr.dout_oe_n = 1'b0;
    wr.fetch     = 1'b0;
  endfunction : wr

  // --------------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------------
  seq_state_s s_reg;
  seq_state_s s_next;

  always_comb begin
    op_class_e   k;
    logic [3:0]  nc;
    logic [15:0] sp;
    logic [15:0] op1;
    logic [15:0] ret;
    s_next = s_reg;
    k      = (s_reg.cyc == 4'h1) ? op_class : s_reg.cls;
    nc     = s_reg.cyc + 4'h1;
    sp     = s_reg.r.sp;
    op1    = s_reg.r.pc + 16'h0001;
    ret    = op1;
    if (s_reg.phase == PH_WAIT) begin
      // Held stacking frame; core halts on repeated reads
      if (wake) begin
        s_next.phase = PH_RUN;
        s_next.cyc   = 4'h1;
        s_next.bus   = rd(s_reg.r.pc, 1'b1);
      end else begin
        // Stack pointer already holds the original value minus seven
        s_next.bus   = rd(sp, 1'b0);
      end
    end else begin
      s_next.cls = k;
      // Data returned by the cycle now ending
      unique case (k)
        CL_PULL_A: if (s_reg.cyc == 4'h4) s_next.r.a = data_in;
        CL_PULL_B: if (s_reg.cyc == 4'h4) s_next.r.b = data_in;
        CL_PULL_X: begin
          if (s_reg.cyc == 4'h4) s_next.r.x[15:8] = data_in;
          if (s_reg.cyc == 4'h5) s_next.r.x[7:0]  = data_in;
        end
        CL_RETURN: begin
          if (s_reg.cyc == 4'h4) s_next.hold = data_in;
          if (s_reg.cyc == 4'h5) ret = {s_reg.hold, data_in};
        end
        default: ;
      endcase
      if (s_reg.cyc == cycles_of(k)) begin
        // Last cycle: commit register effects and fetch the next opcode, or enter the wait phase for CL_WAIT
        unique case (k)
          CL_SP_INC:             s_next.r.sp = sp + 16'h0001;
          CL_SP_DEC:             s_next.r.sp = sp - 16'h0001;
          CL_X_INC:              s_next.r.x  = s_reg.r.x + 16'h0001;
          CL_X_DEC:              s_next.r.x  = s_reg.r.x - 16'h0001;
          CL_X_TO_SP:            s_next.r.sp = s_reg.r.x;
          CL_SP_TO_X:            s_next.r.x  = sp;
          CL_PUSH_A, CL_PUSH_B:  s_next.r.sp = sp - 16'h0001;
          CL_PULL_A, CL_PULL_B:  s_next.r.sp = sp + 16'h0001;
          CL_PUSH_X:             s_next.r.sp = sp - 16'h0002;
          CL_PULL_X, CL_RETURN:  s_next.r.sp = sp + 16'h0002;
          CL_WAIT:               s_next.r.sp = sp - `WAIT_SP_OFFSET;
          default: ;
        endcase
        if (k == CL_WAIT) begin
          s_next.phase = PH_WAIT;
          s_next.r.pc  = op1;
          s_next.bus   = rd(sp - `WAIT_SP_OFFSET, 1'b0);
        end else begin
          s_next.r.pc  = ret;
          s_next.cyc   = 4'h1;
          s_next.bus   = rd(ret, 1'b1);
        end
      end else begin
        s_next.cyc = nc;
        if (nc == 4'h2) begin
          s_next.bus = rd(op1, 1'b0);
        end else begin
          unique case (k)
            CL_IRR_FFFF, CL_X_INC, CL_X_DEC, CL_X_TO_SP:
              s_next.bus = rd(`DUMMY_ADDR, 1'b0);
            CL_SP_INC, CL_SP_DEC, CL_SP_TO_X:
              s_next.bus = rd(sp, 1'b0);
            CL_PUSH_A:
              s_next.bus = wr(sp, s_reg.r.a);
            CL_PUSH_B:
              s_next.bus = wr(sp, s_reg.r.b);
            CL_PULL_A, CL_PULL_B, CL_PULL_X, CL_RETURN:
              s_next.bus = rd(sp + {12'h000, nc} - 16'h0003, 1'b0);
            CL_PUSH_X:
              s_next.bus = (nc == 4'h3) ? wr(sp, s_reg.r.x[7:0])
                                        : wr(sp - 16'h0001, s_reg.r.x[15:8]);
            CL_WAIT: begin
              unique case (nc)
                4'h3:    s_next.bus = wr(sp, op1[7:0]);
                4'h4:    s_next.bus = wr(sp - 16'h0001, op1[15:8]);
                4'h5:    s_next.bus = wr(sp - 16'h0002, s_reg.r.x[7:0]);
                4'h6:    s_next.bus = wr(sp - 16'h0003, s_reg.r.x[15:8]);
                4'h7:    s_next.bus = wr(sp - 16'h0004, s_reg.r.a);
                4'h8:    s_next.bus = wr(sp - 16'h0005, s_reg.r.b);
                default: s_next.bus = wr(sp - 16'h0006, s_reg.r.ccr);
              endcase
            end
            default:
              s_next.bus = rd(op1, 1'b0);
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s_reg.phase <= PH_RUN;
      s_reg.cls   <= CL_INHERENT;
      s_reg.cyc   <= 4'h1;
      s_reg.hold  <= 8'h00;
      s_reg.r.pc  <= `RST_PC;
      s_reg.r.sp  <= `RST_SP;
      s_reg.r.x   <= `RST_X;
      s_reg.r.a   <= `RST_ACC;
      s_reg.r.b   <= `RST_ACC;
      s_reg.r.ccr <= `RST_CCR;
      s_reg.bus   <= '{addr: `RST_PC, rw: 1'b1, dout: 8'h00, dout_oe_n: 1'b1, fetch: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all from state flops
  // --------------------------------------------------------------------------
  assign addr         = s_reg.bus.addr;
  assign rw           = s_reg.bus.rw;
  assign data_out     = s_reg.bus.dout;
  assign data_oe_n    = s_reg.bus.dout_oe_n;
  assign opcode_fetch = s_reg.bus.fetch;
  assign wait_halt    = (s_reg.phase == PH_WAIT);
  assign cpu_regs     = s_reg.r;

endmodule : implied_mode_bus_cycle_sequencer
`default_nettype wire

// ==== bench/implied_seq_mem.sv ====
// Memory and peripheral model on the far side of the sequencer bus.
// Assumes one bus cycle per clock and writes taken at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module implied_seq_mem (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic        rw,
  input  wire logic [7:0]  data_out,
  output logic [7:0]       data_in
);
  logic [7:0] store [logic [15:0]];
  logic [7:0] last_reg = 8'hA5;

  function automatic logic [7:0] peek(input logic [15:0] a);
    return store.exists(a) ? store[a] : a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : peek

  // Reads leave the store untouched
  always @(posedge clk) begin
    if (!rw) store[addr] = data_out;
    else last_reg = data_in;
  end

  // Released bus shows the inverse of the last byte
  always @(negedge clk or addr or rw) begin
    data_in = rw ? peek(addr) : ~last_reg;
  end
endmodule : implied_seq_mem
`default_nettype wire

// ==== bench/implied_seq_chk.sv ====
// Port assertions for the implied-mode sequencer.
// Assumes it is bound to the sequencer top module.
`timescale 1ns/1ps
`default_nettype none
module implied_seq_chk
  import implied_seq_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  data_in,
  input var  op_class_e   op_class,
  input wire logic        wake,
  input wire logic [15:0] addr,
  input wire logic        rw,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n,
  input wire logic        opcode_fetch,
  input wire logic        wait_halt,
  input var  cpu_regs_s   cpu_regs
);
  logic [1:0] live_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) live_reg <= 2'b00;
    else live_reg <= {live_reg[0], 1'b1};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!live_reg[1]);

  property p_inh; opcode_fetch && op_class == CL_INHERENT |=> rw && !opcode_fetch &&
    addr == $past(addr) + 16'h0001 ##1 opcode_fetch && addr == $past(addr); endproperty
  a_inh: assert property (p_inh) else $error("inherent sequence wrong");
  property p_irr; opcode_fetch && op_class == CL_IRR_FFFF |=> rw && addr == $past(addr) + 16'h0001
    ##1 rw && addr == 16'hFFFF; endproperty
  a_irr: assert property (p_irr) else $error("three-read op wrong");
  property p_spstep; opcode_fetch && op_class inside {CL_SP_INC, CL_SP_DEC} |=> ##1 rw &&
    addr == $past(cpu_regs.sp, 2); endproperty
  a_spstep: assert property (p_spstep) else $error("stack step address wrong");
  property p_xstep; opcode_fetch && op_class inside {CL_X_INC, CL_X_DEC, CL_X_TO_SP} |=> ##1 rw &&
    addr == 16'hFFFF ##1 opcode_fetch; endproperty
  a_xstep: assert property (p_xstep) else $error("index step wrong");
  property p_push; opcode_fetch && op_class == CL_PUSH_A |=> ##1 !rw && !data_oe_n &&
    addr == $past(cpu_regs.sp, 2) && data_out == $past(cpu_regs.a, 2); endproperty
  a_push: assert property (p_push) else $error("push write wrong");
  property p_tsx; opcode_fetch && op_class == CL_SP_TO_X |=> ##1 rw && addr == $past(cpu_regs.sp, 2)
    ##1 cpu_regs.x == $past(cpu_regs.sp, 3); endproperty
  a_tsx: assert property (p_tsx) else $error("stack to index wrong");
  property p_pull; opcode_fetch && op_class == CL_PULL_B |=> ##1 rw && addr == $past(cpu_regs.sp, 2)
    ##1 rw && addr == $past(cpu_regs.sp, 3) + 16'h0001 ##1 cpu_regs.b == $past(data_in); endproperty
  a_pull: assert property (p_pull) else $error("pull wrong");
  property p_pushx; opcode_fetch && op_class == CL_PUSH_X |=> ##2 !rw && addr == $past(cpu_regs.sp, 3) -
    16'h0001 && data_out == $past(cpu_regs.x[15:8], 3) ##1 cpu_regs.sp == $past(cpu_regs.sp, 4) - 16'h0002;
  endproperty
  a_pushx: assert property (p_pushx) else $error("index push wrong");
  property p_ret; opcode_fetch && op_class == CL_RETURN |=> ##3 rw && addr == $past(cpu_regs.sp, 4) +
    16'h0002 ##1 opcode_fetch && addr == {$past(data_in, 2), $past(data_in)}; endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_wait; opcode_fetch && op_class == CL_WAIT |=> !opcode_fetch [*8] ##1 wait_halt; endproperty
  a_wait: assert property (p_wait) else $error("wait length wrong");
  property p_halt; wait_halt |-> rw && data_oe_n && addr == cpu_regs.sp; endproperty
  a_halt: assert property (p_halt) else $error("wait bus state wrong");

  c_ret: cover property (opcode_fetch && op_class == CL_RETURN);
  c_pullx: cover property (opcode_fetch && op_class == CL_PULL_X);
  c_wake: cover property (wait_halt && wake);
endmodule : implied_seq_chk
bind implied_mode_bus_cycle_sequencer implied_seq_chk i_implied_seq_chk (.clk(clk), .arst_n(arst_n),
  .data_in(data_in), .op_class(op_class), .wake(wake), .addr(addr), .rw(rw), .data_out(data_out),
  .data_oe_n(data_oe_n), .opcode_fetch(opcode_fetch), .wait_halt(wait_halt), .cpu_regs(cpu_regs));
`default_nettype wire

// ==== bench/tb_implied_mode_bus_cycle_sequencer.sv ====
// Self-checking bench: reference model of bus cycles per opcode class.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "implied_seq_regs.svh"
module tb_implied_mode_bus_cycle_sequencer
  import implied_seq_pkg::*;
;
  logic        clk, arst_n, wake, rw, data_oe_n, opcode_fetch, wait_halt, waiting;
  logic [7:0]  data_in, data_out, a, b;
  logic [15:0] addr, pc, sp, x, npc, t;
  op_class_e   op_class, cls;
  cpu_regs_s   cpu_regs;
  logic [24:0] exp_q [$];
  logic [24:0] e;
  logic [71:0] g;
  logic [3:0]  r;
  integer      fail_count, checks, seed, n, wcnt, cyc;

  implied_mode_bus_cycle_sequencer i_implied_mode_bus_cycle_sequencer (.clk(clk), .arst_n(arst_n),
    .data_in(data_in), .op_class(op_class), .wake(wake), .addr(addr), .rw(rw), .data_out(data_out),
    .data_oe_n(data_oe_n), .opcode_fetch(opcode_fetch), .wait_halt(wait_halt), .cpu_regs(cpu_regs));
  implied_seq_mem i_implied_seq_mem (.clk(clk), .addr(addr), .rw(rw), .data_out(data_out), .data_in(data_in));

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [15:0] ad);
    exp_q.push_back({ad, 1'b1, 8'h00});
  endtask : rd
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    exp_q.push_back({ad, 1'b0, d});
  endtask : wr
  task automatic report_and_stop;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence: every class once, then random classes
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h25762f6a; arst_n = 1'b0; wake = 1'b0; op_class = CL_INHERENT; waiting = 1'b0;
    pc = `RST_PC; sp = `RST_SP; x = 16'h0000; a = 8'h00; b = 8'h00;
    fail_count = 0; checks = 0; n = 0; wcnt = 0; cyc = 0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(posedge clk);
    while (n < 300) begin
      @(negedge clk);
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        g = 72'({addr, rw, data_out, data_oe_n, opcode_fetch, wait_halt});
        chk(g, 72'({e, e[8], 2'b00}));
        r = 4'($random(seed));
        wake = r[0];
      end else if (waiting) begin
        chk(72'({addr, rw, data_oe_n, wait_halt}), 72'({sp, 3'b111}));
        wcnt = wcnt + 1;
        wake = (wcnt == 4);
        if (wcnt == 4) waiting = 1'b0;
      end else begin
        chk(72'({addr, rw, data_oe_n, opcode_fetch, wait_halt}), 72'({pc, 4'b1110}));
        chk(cpu_regs, {pc, sp, x, a, b, 8'h00});
        r = (n < 16) ? n[3:0] : 4'($random(seed));
        cls = op_class_e'(r);
        op_class = cls;
        npc = pc + 16'h0001;
        rd(npc);
        case (cls)
          CL_IRR_FFFF: rd(`DUMMY_ADDR);
          CL_SP_INC: begin rd(sp); sp = sp + 16'h0001; end
          CL_SP_DEC: begin rd(sp); sp = sp - 16'h0001; end
          CL_X_INC: begin rd(`DUMMY_ADDR); x = x + 16'h0001; end
          CL_X_DEC: begin rd(`DUMMY_ADDR); x = x - 16'h0001; end
          CL_X_TO_SP: begin rd(`DUMMY_ADDR); sp = x; end
          CL_SP_TO_X: begin rd(sp); x = sp; end
          CL_PUSH_A, CL_PUSH_B: begin wr(sp, cls == CL_PUSH_A ? a : b); sp = sp - 16'h0001; end
          CL_PULL_A, CL_PULL_B: begin
            rd(sp); rd(sp + 16'h0001);
            if (cls == CL_PULL_A) a = i_implied_seq_mem.peek(sp + 16'h0001);
            else b = i_implied_seq_mem.peek(sp + 16'h0001);
            sp = sp + 16'h0001;
          end
          CL_PUSH_X: begin wr(sp, x[7:0]); wr(sp - 16'h0001, x[15:8]); sp = sp - 16'h0002; end
          CL_PULL_X, CL_RETURN: begin
            rd(sp); rd(sp + 16'h0001); rd(sp + 16'h0002);
            t = {i_implied_seq_mem.peek(sp + 16'h0001), i_implied_seq_mem.peek(sp + 16'h0002)};
            if (cls == CL_RETURN) npc = t;
            else x = t;
            sp = sp + 16'h0002;
          end
          CL_WAIT: begin
            wr(sp, npc[7:0]); wr(sp - 16'h0001, npc[15:8]); wr(sp - 16'h0002, x[7:0]);
            wr(sp - 16'h0003, x[15:8]); wr(sp - 16'h0004, a); wr(sp - 16'h0005, b); wr(sp - 16'h0006, 8'h00);
            sp = sp - `WAIT_SP_OFFSET;
            waiting = 1'b1;
            wcnt = 0;
          end
          default: ;
        endcase
        pc = npc;
        n = n + 1;
      end
    end
    report_and_stop();
  end
endmodule : tb_implied_mode_bus_cycle_sequencer
`default_nettype wire
